/* src/spl_top.sv */
// STN pixel level path: queue, table lookup, frame duty dither, panel shifter.
// Assumes one AHB-Lite master, frame and line pulses on CLK from the timing
// generator, and a panel side that takes a beat when VD_READY is high.
`timescale 1ns/1ps
`include "spl_map.svh"

// Word queue with registered ready toward the source
module spl_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Filling side
    input  wire logic                  in_valid,
    input  wire logic [W-1:0]          in_data,
    output logic                       in_ready,
    // Draining side
    output logic                       out_valid,
    output logic [W-1:0]               out_data,
    input  wire logic                  out_ready,
    // Fill level
    output logic [$clog2(D+1)-1:0]     level
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;   // Storage
        logic [AW-1:0]       wp;    // Write pointer
        logic [AW-1:0]       rp;    // Read pointer
        logic [CW-1:0]       cnt;   // Words held
        logic                rdy;   // Not full
    } spl_fst_t;

    localparam spl_fst_t FRST = '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};

    spl_fst_t q;
    spl_fst_t d;
    logic     push;
    logic     pop;

    // Push, pop and count
    always_comb begin
        push = in_valid && q.rdy;
        pop  = (q.cnt != '0) && out_ready;
        d    = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = q.rp + AW'(1);
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        d.rdy = (d.cnt != CW'(D));
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= FRST;
        end else begin
            q <= d;
        end
    end

    assign in_ready  = q.rdy;
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign level     = q.cnt;
endmodule // spl_fifo

// Notes on behaviour
// RL1: 4-level gray code n picks blue nibble n
// RL2: 16-level gray uses pixel value directly
// RL3: 256-color splits pixel into 3/3/2 codes
// RL4: red and green codes pick 32-bit table nibbles
// RL5: blue code picks 16-bit blue table nibble
// RL6: 4096-color uses 4/4/4 levels, no tables
// RL7: non-mono levels go through dithered duty modulation
// RL8: level sets fraction of lit frames, table
// RL9: dual scan drives both halves, nibble each
// RL10: single 4-bit uses lower lines, upper zero
// RL11: single 8-bit uses all eight lines
// RL12: color shifts R, G, B consecutively
// RL13: 4096-color keeps stored component order
// RL14: monochrome serializes raw bits, no processing
// RL15: frame counter plus position gives dither phase
module spl_top
    import spl_pkg::*;
(
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    // AHB-Lite slave
    input  wire spl_pkg::spl_ahb_req_t AHB,
    output logic                       HREADYOUT,
    output logic [31:0]                HRDATA,
    output logic                       HRESP,
    // Pixel words from the fetch side
    input  wire logic                  IN_VALID,
    input  wire logic [31:0]           IN_DATA,
    output logic                       IN_READY,
    // Timing generator pulses
    input  wire logic                  FRAME_START,
    input  wire logic                  LINE_START,
    // Panel data lines
    output logic [7:0]                 VD,
    output logic                       VD_VALID,
    input  wire logic                  VD_READY
);
    import spl_pkg::*;

    localparam spl_core_t CRST = '{st: S_LOAD, red: `SPL_RED_RST,
        green: `SPL_GREEN_RST, blue: `SPL_BLUE_RST, hrdy: 1'b1, default: '0};

    spl_core_t   q;          // Current state
    spl_core_t   d;          // Next state
    logic        f_valid;    // Queue has a word
    logic [31:0] f_data;     // Queue head
    logic        f_ready;    // Engine takes a word
    logic [5:0]  f_level;    // Queue fill
    logic        pop;        // Word taken this cycle
    logic        sel;        // Bus transfer accepted
    logic        adv;        // Shifter moves this cycle
    logic [7:0]  ph;         // Dither phase
    logic [3:0]  lv_u;       // Upper level
    logic [3:0]  lv_l;       // Lower level
    logic [31:0] msh_u;      // Mono shifted upper
    logic [31:0] msh_l;      // Mono shifted lower
    logic        dot_u;      // Upper dot
    logic        dot_l;      // Lower dot
    logic [3:0]  wmax;       // Dots per beat
    logic [4:0]  last_pix;   // Last pixel of a word
    logic [1:0]  last_comp;  // Last component of a pixel

    // Input queue
    spl_fifo #(.W(`SPL_FIFO_W), .D(`SPL_FIFO_D)) u_fifo (
        .clk       (CLK),
        .rst_n     (RESETN),
        .in_valid  (IN_VALID),
        .in_data   (IN_DATA),
        .in_ready  (IN_READY),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready),
        .level     (f_level)
    );

    // Duty fraction per level, spread over the phase
    function automatic logic frc_dot(input logic [3:0] lv, input logic [7:0] p);
        logic [2:0] num;
        logic [2:0] den;
        logic [7:0] r;
        logic [7:0] m;
        num = 3'h0;
        den = 3'h1;
        unique case (lv)
            4'hF: {num, den} = {3'h1, 3'h1};
            4'hE: {num, den} = {3'h6, 3'h7};
            4'hD: {num, den} = {3'h4, 3'h5};
            4'hC: {num, den} = {3'h3, 3'h4};
            4'hB: {num, den} = {3'h5, 3'h7};
            4'hA: {num, den} = {3'h2, 3'h3};
            4'h9: {num, den} = {3'h3, 3'h5};
            4'h8: {num, den} = {3'h4, 3'h7};
            4'h7: {num, den} = {3'h1, 3'h2};
            4'h6: {num, den} = {3'h3, 3'h7};
            4'h5: {num, den} = {3'h2, 3'h5};
            4'h4: {num, den} = {3'h1, 3'h3};
            4'h3: {num, den} = {3'h1, 3'h4};
            4'h2: {num, den} = {3'h1, 3'h5};
            4'h1: {num, den} = {3'h1, 3'h7};
            4'h0: {num, den} = {3'h0, 3'h1};
        endcase
        r = p % {5'h0, den};
        m = 8'((r * {5'h0, num}) % {5'h0, den});
        return m < {5'h0, num}; // RL8
    endfunction

    // Level of one component of one pixel of a word
    function automatic logic [3:0] lvl_of(input logic [31:0] w, input logic [4:0] p,
                                          input logic [1:0] c);
        logic [31:0] s;
        logic [7:0]  b;
        logic [11:0] x;
        s = '0;
        b = '0;
        x = '0;
        lvl_of = 4'h0;
        case (q.mode)
            `SPL_MODE_GRAY4: begin
                s = w << {p, 1'b0};
                lvl_of = q.blue[{s[31:30], 2'h0} +: 4]; // RL1
            end
            `SPL_MODE_GRAY16: begin
                s = w << {p, 2'h0};
                lvl_of = s[31:28]; // RL2
            end
            `SPL_MODE_C256: begin
                s = w << {p, 3'h0};
                b = s[31:24]; // RL3
                unique case (c)
                    2'h0: lvl_of = q.red[{b[7:5], 2'h0} +: 4]; // RL4
                    2'h1: lvl_of = q.green[{b[4:2], 2'h0} +: 4]; // RL4
                    default: lvl_of = q.blue[{b[1:0], 2'h0} +: 4]; // RL5
                endcase
            end
            `SPL_MODE_C4096: begin
                x = p[0] ? w[11:0] : w[27:16]; // RL6
                x = x << {c, 2'h0}; // RL13
                lvl_of = x[11:8];
            end
            default: lvl_of = 4'h0;
        endcase
    endfunction

    // Per-dot helpers
    assign ph    = q.frame + q.line + q.col; // RL15
    assign lv_u  = lvl_of(q.wu, q.pix, q.comp);
    assign lv_l  = lvl_of(q.wl, q.pix, q.comp);
    assign msh_u = q.wu << q.pix;
    assign msh_l = q.wl << q.pix;
    assign dot_u = (q.mode == `SPL_MODE_MONO) ? msh_u[31] : frc_dot(lv_u, ph); // RL7 RL14
    assign dot_l = (q.mode == `SPL_MODE_MONO) ? msh_l[31] : frc_dot(lv_l, ph); // RL7 RL14
    assign wmax  = (q.scan == `SPL_SCAN_SINGLE8) ? 4'h8 : 4'h4;
    assign last_comp = (q.mode == `SPL_MODE_C256 || q.mode == `SPL_MODE_C4096) ? 2'h2 : 2'h0;
    assign f_ready = q.en && (q.st != S_SHIFT);
    assign pop   = f_valid && f_ready;
    assign adv   = q.en && (q.st == S_SHIFT) && (!q.vdv || VD_READY);
    assign sel   = AHB.hsel && AHB.hready && AHB.htrans[1];

    // Pixels per word
    always_comb begin
        case (q.mode)
            `SPL_MODE_GRAY4:  last_pix = 5'h0F;
            `SPL_MODE_GRAY16: last_pix = 5'h07;
            `SPL_MODE_C256:   last_pix = 5'h03;
            `SPL_MODE_C4096:  last_pix = 5'h01;
            default:          last_pix = 5'h1F;
        endcase
    end

    // Next state: bus, counters, engine
    always_comb begin
        d = q;
        d.hrdy  = 1'b1;
        d.hresp = 1'b0;
        // Write data phase
        if (q.wpend) begin
            case (q.waddr)
                `SPL_CTRL_OFS: begin
                    d.en   = AHB.hwdata[`SPL_CTRL_EN];
                    d.mode = AHB.hwdata[`SPL_CTRL_MODE +: 3];
                    d.scan = AHB.hwdata[`SPL_CTRL_SCAN +: 2];
                end
                `SPL_RED_OFS:   d.red   = AHB.hwdata;
                `SPL_GREEN_OFS: d.green = AHB.hwdata;
                `SPL_BLUE_OFS:  d.blue  = AHB.hwdata[15:0];
                default: ;
            endcase
        end
        // Address phase
        d.wpend  = sel && AHB.hwrite;
        d.waddr  = AHB.haddr[7:0];
        d.hrdata = 32'h0;
        if (sel && !AHB.hwrite) begin
            case (AHB.haddr[7:0])
                `SPL_CTRL_OFS:  d.hrdata = {22'h0, d.scan, 1'b0, d.mode, 3'h0, d.en};
                `SPL_RED_OFS:   d.hrdata = d.red;
                `SPL_GREEN_OFS: d.hrdata = d.green;
                `SPL_BLUE_OFS:  d.hrdata = {16'h0, d.blue};
                `SPL_STAT_OFS:  d.hrdata = {17'h0, q.vdv, f_level, q.frame};
                default:        d.hrdata = 32'h0;
            endcase
        end
        // Beat handed to the panel
        if (q.vdv && VD_READY) begin
            d.vdv = 1'b0;
        end
        // Frame and line sequence
        if (LINE_START) begin
            d.line = q.line + 8'h01; // RL15
        end
        if (FRAME_START) begin
            d.frame = q.frame + 8'h01; // RL15
            d.line  = 8'h00;
        end
        // Engine
        unique case (q.st)
            S_LOAD: begin
                if (pop) begin
                    d.wu   = f_data;
                    d.pix  = 5'h00;
                    d.comp = 2'h0;
                    d.st   = (q.scan == `SPL_SCAN_DUAL4) ? S_LOAD2 : S_SHIFT; // RL9
                end
            end
            S_LOAD2: begin
                if (pop) begin
                    d.wl = f_data;
                    d.st = S_SHIFT;
                end
            end
            S_SHIFT: begin
                if (adv) begin
                    // Place dots on the lines
                    case (q.scan)
                        `SPL_SCAN_DUAL4:   d.acc = {q.acc[6:4], dot_u, q.acc[2:0], dot_l}; // RL9
                        `SPL_SCAN_SINGLE4: d.acc = {4'h0, q.acc[2:0], dot_u}; // RL10
                        default:           d.acc = {q.acc[6:0], dot_u}; // RL11
                    endcase
                    d.cnt = q.cnt + 4'h1;
                    if (d.cnt == wmax) begin
                        d.vd  = d.acc;
                        d.vdv = 1'b1;
                        d.cnt = 4'h0;
                    end
                    // Step component, then pixel
                    if (q.comp == last_comp) begin
                        d.comp = 2'h0;
                        d.pix  = q.pix + 5'h01;
                        d.col  = q.col + 8'h01;
                        if (q.pix == last_pix) begin
                            d.st = S_LOAD;
                        end
                    end else begin
                        d.comp = q.comp + 2'h1; // RL12
                    end
                end
            end
            default: d.st = S_LOAD;
        endcase
        // New line restarts the column
        if (LINE_START) begin
            d.col = 8'h00;
        end
        // Disabled: park, drop partial beat
        if (!q.en) begin
            d.st  = S_LOAD;
            d.cnt = 4'h0;
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= CRST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign HREADYOUT = q.hrdy;
    assign HRDATA    = q.hrdata;
    assign HRESP     = q.hresp;
    assign VD        = q.vd;
    assign VD_VALID  = q.vdv;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_gray4;
        (q.st == S_SHIFT && q.mode == `SPL_MODE_GRAY4 && q.pix == 5'h00)
            |-> lv_u == q.blue[{q.wu[31:30], 2'h0} +: 4];
    endproperty
    a_gray4: assert property (p_gray4) else $error("gray4 lookup wrong"); // RL1

    property p_gray16;
        (q.st == S_SHIFT && q.mode == `SPL_MODE_GRAY16 && q.pix == 5'h01)
            |-> lv_u == q.wu[27:24];
    endproperty
    a_gray16: assert property (p_gray16) else $error("gray16 not direct"); // RL2

    property p_red;
        (q.st == S_SHIFT && q.mode == `SPL_MODE_C256 && q.pix == 5'h00 && q.comp == 2'h0)
            |-> lv_u == q.red[{q.wu[31:29], 2'h0} +: 4];
    endproperty
    a_red: assert property (p_red) else $error("red lookup wrong"); // RL3 RL4

    property p_blue;
        (q.st == S_SHIFT && q.mode == `SPL_MODE_C256 && q.pix == 5'h00 && q.comp == 2'h2)
            |-> lv_u == q.blue[{q.wu[25:24], 2'h0} +: 4];
    endproperty
    a_blue: assert property (p_blue) else $error("blue lookup wrong"); // RL5

    property p_c4096;
        (q.st == S_SHIFT && q.mode == `SPL_MODE_C4096 && q.pix == 5'h00 && q.comp == 2'h1)
            |-> lv_u == q.wu[23:20];
    endproperty
    a_c4096: assert property (p_c4096) else $error("4096 level wrong"); // RL6 RL13

    property p_duty;
        (adv && q.mode != `SPL_MODE_MONO && (lv_u == 4'hF || lv_u == 4'h0))
            |-> dot_u == lv_u[0];
    endproperty
    a_duty: assert property (p_duty) else $error("full or zero duty wrong"); // RL7 RL8

    property p_mono;
        (adv && q.mode == `SPL_MODE_MONO && q.pix == 5'h00) |-> dot_u == q.wu[31];
    endproperty
    a_mono: assert property (p_mono) else $error("mono bit wrong"); // RL14

    property p_beat;
        (adv && q.cnt == wmax - 4'h1) |=> VD_VALID && VD == $past(d.acc);
    endproperty
    a_beat: assert property (p_beat) else $error("beat not emitted"); // RL9 RL11

    property p_upper;
        (VD_VALID && q.scan == `SPL_SCAN_SINGLE4 && $past(q.scan) == `SPL_SCAN_SINGLE4)
            |-> VD[7:4] == 4'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper lines used"); // RL10

    property p_rgb;
        (adv && last_comp == 2'h2 && q.comp == 2'h0) |=> q.comp == 2'h1;
    endproperty
    a_rgb: assert property (p_rgb) else $error("component order wrong"); // RL12

    c_dual: cover property (adv && q.scan == `SPL_SCAN_DUAL4 ##1 VD_VALID);
    c_word: cover property (q.mode == `SPL_MODE_C256 && q.st == S_SHIFT ##1 q.st == S_LOAD);
    c_full: cover property (!IN_READY);
endmodule // spl_top

/* src/spl_map.svh */
// Offsets, field positions, reset values and codes of the pixel level block.
// Assumes a word-aligned AHB-Lite register window decoded on address bits 7:0.
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH

// Register byte offsets
`define SPL_CTRL_OFS     8'h00
`define SPL_RED_OFS      8'h04
`define SPL_GREEN_OFS    8'h08
`define SPL_BLUE_OFS     8'h0C
`define SPL_STAT_OFS     8'h10

// Control field positions
`define SPL_CTRL_EN      0
`define SPL_CTRL_MODE    4
`define SPL_CTRL_SCAN    8

// Table reset values (red and green map code k to 2k+1, blue maps code k to 5k)
`define SPL_RED_RST      32'hFDB97531
`define SPL_GREEN_RST    32'hFDB97531
`define SPL_BLUE_RST     16'hFA50

// Pixel mode codes
`define SPL_MODE_MONO    3'h0
`define SPL_MODE_GRAY4   3'h1
`define SPL_MODE_GRAY16  3'h2
`define SPL_MODE_C256    3'h3
`define SPL_MODE_C4096   3'h4

// Display type codes
`define SPL_SCAN_DUAL4   2'h0
`define SPL_SCAN_SINGLE4 2'h1
`define SPL_SCAN_SINGLE8 2'h2

// Input queue shape
`define SPL_FIFO_W       32
`define SPL_FIFO_D       32

`endif

/* src/spl_pkg.sv */
// Types of the pixel level block: engine states, bus carrier, core state.
// Assumes the constants of spl_map.svh are used alongside.
package spl_pkg;

    // Engine states, one-hot
    typedef enum logic [2:0] {
        S_LOAD  = 3'b001,
        S_LOAD2 = 3'b010,
        S_SHIFT = 3'b100
    } spl_st_t;

    // AHB-Lite request from the master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } spl_ahb_req_t;

    // Whole state of the core
    typedef struct packed {
        spl_st_t     st;
        logic [31:0] wu;
        logic [31:0] wl;
        logic [4:0]  pix;
        logic [1:0]  comp;
        logic [7:0]  acc;
        logic [3:0]  cnt;
        logic [7:0]  vd;
        logic        vdv;
        logic [7:0]  frame;
        logic [7:0]  line;
        logic [7:0]  col;
        logic        en;
        logic [2:0]  mode;
        logic [1:0]  scan;
        logic [31:0] red;
        logic [31:0] green;
        logic [15:0] blue;
        logic        wpend;
        logic [7:0]  waddr;
        logic [31:0] hrdata;
        logic        hrdy;
        logic        hresp;
    } spl_core_t;

endpackage

/* testbench/spl_panel.sv */
// Panel side model: takes beats from the panel data lines and keeps them.
// Assumes the beat leaves the block at an edge with valid and ready both high.
`timescale 1ns/1ps

module spl_panel (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Beat from the block
    input  wire logic [7:0] vd,
    input  wire logic       vd_valid,
    output logic            vd_ready,
    // Pacing, 1 takes one beat in four cycles
    input  wire logic       slow
);
    logic [7:0] beats[$];  // Taken beats, oldest first
    logic [1:0] ph_q;      // Pacing phase

    // Ready pacing and beat capture
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q     <= 2'h0;
            vd_ready <= 1'b0;
        end else begin
            ph_q     <= ph_q + 2'h1;
            vd_ready <= !slow || (ph_q == 2'h3);
            // Beat leaves only on a joint high
            if (vd_valid && vd_ready) begin
                beats.push_back(vd);
            end
        end
    end
endmodule // spl_panel

/* testbench/spl_top_tb.sv */
// Bench of the pixel level block: registers, queue, lookup, duty, panel packing.
// Assumes spl_panel on the panel side and the constants of spl_map.svh.
`timescale 1ns/1ps
`include "spl_map.svh"

module spl_top_tb;
    import spl_pkg::*;
    logic         clk;          // 200 MHz clock
    logic         rst_n;        // Reset, active low
    spl_ahb_req_t req;          // Master request
    spl_ahb_req_t ahb;          // Request with ready fed back
    logic         hready;       // Slave ready
    logic [31:0]  hrdata;       // Read data
    logic         hresp;        // Slave response
    logic         in_valid;     // Word offered
    logic [31:0]  in_data;      // Word value
    logic         in_ready;     // Queue has room
    logic         frame_start;  // Frame pulse
    logic         line_start;   // Line pulse
    logic [7:0]   vd;           // Panel beat
    logic         vd_valid;     // Beat present
    logic         vd_ready;     // Panel takes beat
    logic         slow;         // Panel pacing
    int           failures;     // Mismatches
    int           checked;      // Comparisons
    logic [31:0]  rd;           // Last read word

    // Ready of the one slave closes the bus
    always_comb begin
        ahb        = req;
        ahb.hready = hready;
    end

    spl_top u_spl_top (
        .CLK(clk), .RESETN(rst_n), .AHB(ahb), .HREADYOUT(hready), .HRDATA(hrdata),
        .HRESP(hresp), .IN_VALID(in_valid), .IN_DATA(in_data), .IN_READY(in_ready),
        .FRAME_START(frame_start), .LINE_START(line_start), .VD(vd),
        .VD_VALID(vd_valid), .VD_READY(vd_ready)
    );

    spl_panel u_spl_panel (
        .clk(clk), .rst_n(rst_n), .vd(vd), .vd_valid(vd_valid), .vd_ready(vd_ready),
        .slow(slow)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic print_verdict();
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Hang cut short
    task automatic tmo();
        failures++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        print_verdict();
    endtask

    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for slave ready, looked at before the edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge clk);
        while (hready !== 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        if (n >= 100) tmo();
    endtask

    // One single word transfer; read data lands in rd
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        req.hsel   <= 1'b1;
        req.haddr  <= {24'h0, a};
        req.htrans <= 2'h2;
        req.hwrite <= wr;
        req.hsize  <= 3'h2;
        wait_rdy();
        @(posedge clk);
        req.htrans <= 2'h0;
        req.hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check(32'(hresp), 32'h0);
        @(posedge clk);
    endtask

    // Offer a word and hold it until taken; valid stays up
    task automatic push(input logic [31:0] d);
        int n;
        in_valid <= 1'b1;
        in_data  <= d;
        n = 0;
        @(negedge clk);
        while (in_ready !== 1'b1 && n < 5000) begin
            n++;
            @(negedge clk);
        end
        if (n >= 5000) tmo();
        @(posedge clk);
    endtask

    // Wait for the beats and compare them in order
    task automatic collect(input logic [7:0] e[$]);
        int n;
        n = 0;
        while (u_spl_panel.beats.size() < e.size() && n < 20000) begin
            n++;
            @(negedge clk);
        end
        if (n >= 20000) tmo();
        foreach (e[i]) check(32'(u_spl_panel.beats[i]), 32'(e[i]));
        u_spl_panel.beats.delete();
        @(posedge clk);
    endtask

    // Push words, then judge the beats
    task automatic stream(input logic [31:0] w[$], input logic [7:0] e[$]);
        foreach (w[i]) push(w[i]);
        in_valid <= 1'b0;
        collect(e);
    endtask

    // Enabled control word
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] s);
        ctl = (32'h1 << `SPL_CTRL_EN) | (32'(m) << `SPL_CTRL_MODE) | (32'(s) << `SPL_CTRL_SCAN);
    endfunction

    // Reset values, write back, unmapped place, frame count
    task automatic t_regs();
        xfer(1'b0, `SPL_CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, `SPL_RED_OFS, 32'h0);
        check(rd, `SPL_RED_RST);
        xfer(1'b0, `SPL_GREEN_OFS, 32'h0);
        check(rd, `SPL_GREEN_RST);
        xfer(1'b0, `SPL_BLUE_OFS, 32'h0);
        check(rd, {16'h0, `SPL_BLUE_RST});
        xfer(1'b1, `SPL_RED_OFS, 32'h13579BDF);
        xfer(1'b0, `SPL_RED_OFS, 32'h0);
        check(rd, 32'h13579BDF);
        xfer(1'b1, `SPL_BLUE_OFS, 32'hFFFF1234);
        xfer(1'b0, `SPL_BLUE_OFS, 32'h0);
        check(rd, 32'h00001234);
        xfer(1'b1, 8'h14, 32'hFFFFFFFF);
        xfer(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        repeat (3) begin
            frame_start <= 1'b1;
            line_start  <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
            line_start  <= 1'b0;
            @(posedge clk);
        end
        xfer(1'b1, `SPL_STAT_OFS, 32'hFF);
        xfer(1'b0, `SPL_STAT_OFS, 32'h0);
        check(rd & 32'hFF, 32'h3);
    endtask

    // Fill the queue while idle, then drain it past a stalling panel
    task automatic t_fill();
        logic [7:0] e[$];
        for (int i = 0; i < `SPL_FIFO_D; i++) push({4{8'(i + 16)}});
        in_valid <= 1'b0;
        @(negedge clk);
        check(32'(in_ready), 32'h0);
        @(posedge clk);
        xfer(1'b0, `SPL_STAT_OFS, 32'h0);
        check((rd >> 8) & 32'h3F, 32'(`SPL_FIFO_D));
        slow <= 1'b1;
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_MONO, `SPL_SCAN_SINGLE8));
        for (int i = 0; i < `SPL_FIFO_D; i++) repeat (4) e.push_back(8'(i + 16));
        collect(e);
        xfer(1'b0, `SPL_STAT_OFS, 32'h0);
        check(rd & 32'h7F00, 32'h0);
    endtask

    // Monochrome on four lines and on both halves
    task automatic t_pack();
        slow <= 1'b0;
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_MONO, `SPL_SCAN_SINGLE4));
        stream({32'hA5C30F96}, {8'h0A, 8'h05, 8'h0C, 8'h03,
                                8'h00, 8'h0F, 8'h09, 8'h06});
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_MONO, `SPL_SCAN_DUAL4));
        stream({32'h12345678, 32'h9ABCDEF0}, {8'h19, 8'h2A, 8'h3B, 8'h4C,
                                              8'h5D, 8'h6E, 8'h7F, 8'h80});
    endtask

    // Gray lookup through the blue table and direct gray levels
    task automatic t_gray();
        slow <= 1'b1;
        xfer(1'b1, `SPL_BLUE_OFS, 32'hF0F0);
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_GRAY4, `SPL_SCAN_SINGLE8));
        stream({32'h1B1B1B1B}, {8'h55, 8'h55});
        xfer(1'b1, `SPL_BLUE_OFS, 32'h0F0F);
        stream({32'h1B1B1B1B}, {8'hAA, 8'hAA});
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_GRAY16, `SPL_SCAN_SINGLE8));
        stream({32'hF0F00FF0}, {8'hA6});
        // Column restart: phase is frame 3 + line 1 + column
        line_start <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
        // Levels 14 and 7 alternate over phases 4 to 11
        stream({32'hE7E7E7E7}, {8'hA2});
    endtask

    // Color codes through three tables, then twelve-bit levels untouched
    task automatic t_color();
        xfer(1'b1, `SPL_RED_OFS, 32'hF0F0F0F0);
        xfer(1'b1, `SPL_GREEN_OFS, 32'h0000FFFF);
        xfer(1'b1, `SPL_BLUE_OFS, 32'hF000);
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_C256, `SPL_SCAN_SINGLE4));
        stream({32'h235C235C}, {8'h0E, 8'h03, 8'h08});
        xfer(1'b1, `SPL_CTRL_OFS, ctl(`SPL_MODE_C4096, `SPL_SCAN_SINGLE4));
        stream({32'h0F0F00F0, 32'h0FF0000F}, {8'h0A, 8'h0B, 8'h01});
    endtask

    // Main sequence
    initial begin
        rst_n       = 1'b0;
        req         = '0;
        in_valid    = 1'b0;
        in_data     = 32'h0;
        frame_start = 1'b0;
        line_start  = 1'b0;
        slow        = 1'b0;
        failures    = 0;
        checked     = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_fill();
        t_pack();
        t_gray();
        t_color();
        print_verdict();
    end
endmodule // spl_top_tb
